// *** design/phy_event_pkg.sv ***
// Package: register map, field layout, reset values and carrier types of the event block
package phy_event_pkg;
  // Register addresses on the management link
  localparam logic [4:0] EVENT_MASK_ADDR = 5'h1D;
  localparam logic [4:0] EVENT_STATUS_ADDR = 5'h1E;
  // Bit positions of the seven events, shared by mask and status
  localparam int RX_ERR_ROLL_BIT = 14;
  localparam int REMOTE_FAULT_BIT = 12;
  localparam int AN_DONE_BIT = 11;
  localparam int LINK_UP_BIT = 10;
  localparam int LINK_DOWN_BIT = 9;
  localparam int LOCK_GAIN_BIT = 8;
  localparam int LOCK_LOSS_BIT = 7;
  // Implemented bits; all others are reserved and read zero
  localparam logic [15:0] EVENT_BITS = 16'h5F80;
  // Values after reset
  localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;
  localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // Event indications from the PHY logic, core clock domain, active high
  typedef struct packed {
    logic rx_err_roll;  // Receive error counter wrapped
    logic remote_fault; // Link partner reports remote fault
    logic an_done;      // Autonegotiation finished
    logic link_up;      // Link came up
    logic link_down;    // Link went down
    logic lock_gain;    // 100 Mbit/s data recovery locked
    logic lock_loss;    // 100 Mbit/s data recovery not locked
  } phy_event_t;

  // One register access from the management side
  typedef struct packed {
    logic wr;           // 1 write, 0 read
    logic [4:0] addr;   // Register address
    logic [15:0] wdata; // Write data
  } mgmt_req_t;

  // Management domain state
  typedef struct packed {
    logic busy;         // Access in flight to the core domain
    logic req_tgl;      // Request toggle
    mgmt_req_t req;     // Held stable while busy
    logic ack_s1;       // Ack toggle synchroniser, first stage
    logic ack_s2;       // Ack toggle synchroniser, second stage
    logic ack_seen;     // Last ack toggle consumed
    logic done;         // One-cycle completion pulse
    logic [15:0] rdata; // Read data returned to the link
  } mgmt_state_t;

  // Core domain state
  typedef struct packed {
    logic req_s1;       // Request toggle synchroniser, first stage
    logic req_s2;       // Request toggle synchroniser, second stage
    logic req_seen;     // Last request toggle served
    logic ack_tgl;      // Ack toggle back to the link domain
    logic [15:0] mask;  // Event mask, 1 disables
    logic [15:0] status; // Latched event status
    logic [15:0] rdata; // Read data, stable until the next access
    logic irq;          // Interrupt indication
  } core_state_t;
endpackage

// *** design/phy_event_interrupt_regs.sv ***
// Event mask and event status registers with interrupt output and link-clock access port
// Summary of operation
// - Mask at 1Dh, 1 disables, resets zero
// - Read-only status at 1Eh, latched, resets zero
// - Bit 14 latches on error counter wrap
// - Bit 12 latches on remote fault
// - Bit 11 latches on autonegotiation done
// - Bit 10 latches when link comes up
// - Bit 9 latches when link goes down
// - Bits 8/7 latch on lock gained/lost

// Two clock domains: the access port runs on the management clock, while events,
// mask, status and the interrupt live on the core clock. An access crosses as a
// toggle that passes two flops, and the answer returns the same way, so the port
// tolerates any ratio and phase between the two clocks at the cost of some latency.
module phy_event_interrupt_regs (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_mgmt_clk,
  input wire logic i_mgmt_valid,
  input wire phy_event_pkg::mgmt_req_t i_mgmt_req,
  output logic o_mgmt_ready,
  output logic o_mgmt_done,
  output logic [15:0] o_mgmt_rdata,
  input wire phy_event_pkg::phy_event_t i_events,
  output logic o_irq
);
  phy_event_pkg::mgmt_state_t mst;      // Management domain state
  phy_event_pkg::mgmt_state_t next_mst; // Its next value
  phy_event_pkg::core_state_t cst;      // Core domain state
  phy_event_pkg::core_state_t next_cst; // Its next value
  logic [15:0] ev_vec;                  // Events placed on their register bits
  logic take;                           // Core serves an access this cycle
  logic rd_status;                      // That access reads the status register

  // The domains talk only through the request and ack toggles; the request
  // word and the core read data are frozen while a toggle is in flight, so they
  // cross without synchronisers of their own.

  // Place each event on its status bit position
  // Reserved positions stay zero here and are masked again where status is set
  always_comb begin
    ev_vec = 16'h0000;
    ev_vec[phy_event_pkg::RX_ERR_ROLL_BIT] = i_events.rx_err_roll;
    ev_vec[phy_event_pkg::REMOTE_FAULT_BIT] = i_events.remote_fault;
    ev_vec[phy_event_pkg::AN_DONE_BIT] = i_events.an_done;
    ev_vec[phy_event_pkg::LINK_UP_BIT] = i_events.link_up;
    ev_vec[phy_event_pkg::LINK_DOWN_BIT] = i_events.link_down;
    ev_vec[phy_event_pkg::LOCK_GAIN_BIT] = i_events.lock_gain;
    ev_vec[phy_event_pkg::LOCK_LOSS_BIT] = i_events.lock_loss;
  end

  // Management side: take one access, toggle a request, wait for the ack toggle
  always_comb begin
    next_mst = mst;
    next_mst.ack_s1 = cst.ack_tgl;
    next_mst.ack_s2 = mst.ack_s1;
    next_mst.done = 1'b0;
    // Done is a one-cycle pulse; the read data stays until the next pulse
    if (!mst.busy && i_mgmt_valid) begin
      // Request fields stay frozen while busy, so the core may sample them directly
      next_mst.req = i_mgmt_req;
      next_mst.req_tgl = ~mst.req_tgl;
      next_mst.busy = 1'b1;
    end else if (mst.busy && (mst.ack_s2 != mst.ack_seen)) begin
      // Core read data is stable until the next request, safe to capture here
      next_mst.ack_seen = mst.ack_s2;
      next_mst.busy = 1'b0;
      next_mst.rdata = cst.rdata;
      next_mst.done = 1'b1;
    end
  end

  // Management domain registers
  // Shared asynchronous reset: both domains come out of it idle together
  always_ff @(posedge i_mgmt_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mst <= '0;
      mst.rdata <= phy_event_pkg::RDATA_RESET;
    end else begin
      mst <= next_mst;
    end
  end

  // Access port outputs, all straight from management flops
  // Ready falls on the edge after an access is taken and rises with done;
  // a request presented while busy is simply not taken, never queued
  assign o_mgmt_ready = !mst.busy;
  assign o_mgmt_done = mst.done;
  assign o_mgmt_rdata = mst.rdata;

  // Core side detects a new request once the toggle has passed two flops
  // Limitation: one access at a time; no second toggle can arrive before the
  // ack goes back, so a request is never missed or served twice
  assign take = cst.req_s2 != cst.req_seen;
  assign rd_status = take && !mst.req.wr && (mst.req.addr == phy_event_pkg::EVENT_STATUS_ADDR);

  // Core side: latch events, serve register accesses, form the interrupt
  always_comb begin
    next_cst = cst;
    next_cst.req_s1 = mst.req_tgl;
    next_cst.req_s2 = cst.req_s1;
    // Events set their bits; reserved positions never set
    next_cst.status = cst.status | (ev_vec & phy_event_pkg::EVENT_BITS);
    // Event latching runs every cycle, so no event is lost while an access is served
    if (take) begin
      next_cst.req_seen = cst.req_s2;
      next_cst.ack_tgl = ~cst.ack_tgl;
      if (mst.req.wr) begin
        // Only the mask is writable; status and other addresses ignore writes
        if (mst.req.addr == phy_event_pkg::EVENT_MASK_ADDR) begin
          next_cst.mask = mst.req.wdata & phy_event_pkg::EVENT_BITS;
        end
        // Writes answer with zero read data
        next_cst.rdata = 16'h0000;
      end else if (mst.req.addr == phy_event_pkg::EVENT_MASK_ADDR) begin
        next_cst.rdata = cst.mask;
      end else if (rd_status) begin
        next_cst.rdata = cst.status;
        // Clear on read, but an event present now stays latched: set beats clear
        next_cst.status = ev_vec & phy_event_pkg::EVENT_BITS;
      end else begin
        // Other addresses are not in this block and read zero
        next_cst.rdata = 16'h0000;
      end
    end
    // Formed from the next values so the interrupt flop follows status and mask
    // on the same edge instead of lagging one more cycle behind them
    next_cst.irq = |(next_cst.status & ~next_cst.mask);
  end

  // Core domain registers
  // Reset leaves every event enabled and nothing latched
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cst <= '0;
      cst.mask <= phy_event_pkg::EVENT_MASK_RESET;
      cst.status <= phy_event_pkg::EVENT_STATUS_RESET;
      cst.rdata <= phy_event_pkg::RDATA_RESET;
    end else begin
      cst <= next_cst;
    end
  end

  // Interrupt output, registered so it never glitches
  assign o_irq = cst.irq;

  // Checks in the core domain
  a_mask_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    take && mst.req.wr && (mst.req.addr == phy_event_pkg::EVENT_MASK_ADDR)
    |=> cst.mask == ($past(mst.req.wdata) & phy_event_pkg::EVENT_BITS))
    else $error("mask not written");
  a_mask_reserved: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (cst.mask & ~phy_event_pkg::EVENT_BITS) == 16'h0000)
    else $error("reserved mask bit set");
  a_status_readonly: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    take && mst.req.wr && (i_events == '0) |=> cst.status == $past(cst.status))
    else $error("status changed by write");

  // Each event sets its own status bit one core cycle later
  a_rollover_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_events.rx_err_roll |=> cst.status[phy_event_pkg::RX_ERR_ROLL_BIT])
    else $error("rollover not latched");
  a_fault_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_events.remote_fault |=> cst.status[phy_event_pkg::REMOTE_FAULT_BIT])
    else $error("remote fault not latched");
  a_an_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_events.an_done |=> cst.status[phy_event_pkg::AN_DONE_BIT])
    else $error("autoneg done not latched");
  a_link_up_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_events.link_up |=> cst.status[phy_event_pkg::LINK_UP_BIT])
    else $error("link up not latched");
  a_link_down_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_events.link_down |=> cst.status[phy_event_pkg::LINK_DOWN_BIT])
    else $error("link down not latched");
  a_lock_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_events.lock_gain || i_events.lock_loss
    |=> (cst.status[phy_event_pkg::LOCK_GAIN_BIT] || !$past(i_events.lock_gain))
    && (cst.status[phy_event_pkg::LOCK_LOSS_BIT] || !$past(i_events.lock_loss)))
    else $error("lock event not latched");
  // Latched bits survive until a status read, and a read keeps live events
  a_hold_latched: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !rd_status |=> (cst.status & $past(cst.status)) == $past(cst.status))
    else $error("status bit lost without read");
  a_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_status |=> cst.status == ($past(ev_vec) & phy_event_pkg::EVENT_BITS)
    && cst.rdata == $past(cst.status))
    else $error("status read clear wrong");
  // Interrupt level against the registered status and mask
  a_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_irq == |(cst.status & ~cst.mask))
    else $error("interrupt level wrong");
  a_status_reserved: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (cst.status & ~phy_event_pkg::EVENT_BITS) == 16'h0000)
    else $error("reserved status bit set");
  a_take_once: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    take |=> !take)
    else $error("access served twice");

  // Checks in the management domain: every taken access is answered in bounded time
  a_access_done: assert property (@(posedge i_mgmt_clk) disable iff (!i_nrst)
    !mst.busy && i_mgmt_valid |=> mst.busy ##[1:20] o_mgmt_done)
    else $error("access never completed");
  a_done_single: assert property (@(posedge i_mgmt_clk) disable iff (!i_nrst)
    o_mgmt_done |=> !o_mgmt_done)
    else $error("done longer than one cycle");
  a_rdata_with_done: assert property (@(posedge i_mgmt_clk) disable iff (!i_nrst)
    $changed(o_mgmt_rdata) |-> o_mgmt_done)
    else $error("read data changed without done");
  a_ready_taken: assert property (@(posedge i_mgmt_clk) disable iff (!i_nrst)
    o_mgmt_ready && i_mgmt_valid |=> !o_mgmt_ready)
    else $error("ready stayed high after take");

  // Main scenarios
  c_status_write: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    take && mst.req.wr && (mst.req.addr == phy_event_pkg::EVENT_STATUS_ADDR));
  c_mask_write: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    take && mst.req.wr && (mst.req.addr == phy_event_pkg::EVENT_MASK_ADDR));
  c_read_nonzero: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_status && (cst.status != 16'h0000));
  c_event_on_read: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_status && (i_events != '0));
  c_irq_rise: cover property (@(posedge i_core_clk) disable iff (!i_nrst) $rose(o_irq));
endmodule

// *** verification/mgmt_host_model.sv ***
// Management host model that drives the access port of the event block
module mgmt_host_model (
  input wire logic i_mgmt_clk,
  input wire logic i_mgmt_ready,
  input wire logic i_mgmt_done,
  output logic o_mgmt_valid,
  output phy_event_pkg::mgmt_req_t o_mgmt_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    o_mgmt_valid = 1'b0;
    o_mgmt_req = '0;
  end
  // One access: hold until taken, then wait for completion within a bound
  task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata);
    int n;
    @(posedge i_mgmt_clk);
    o_mgmt_valid <= 1'b1;
    o_mgmt_req <= {wr, addr, wdata};
    do @(posedge i_mgmt_clk); while (i_mgmt_ready !== 1'b1);
    // Released lines show the inverse so stale values never look held
    o_mgmt_valid <= 1'b0;
    o_mgmt_req <= ~{wr, addr, wdata};
    for (n = 0; n < 40 && i_mgmt_done !== 1'b1; n++) @(posedge i_mgmt_clk);
  endtask
endmodule

// *** verification/phy_event_interrupt_regs_tb_top.sv ***
// Self-checking bench of the event mask and status block
module phy_event_interrupt_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic mgmt_clk = 1'b0;
  logic nrst = 1'b0;
  logic valid;
  logic ready;
  logic done;
  logic [15:0] rdata;
  logic irq;
  phy_event_pkg::mgmt_req_t req;
  phy_event_pkg::phy_event_t ev = '0;
  logic [15:0] exp_q[$]; // Expected read data, oldest first
  int fails = 0;
  int cmp_count = 0;
  logic [6:0] v;
  logic [15:0] x;
  logic [15:0] m;

  phy_event_interrupt_regs phy_event_interrupt_regs_i (.i_core_clk(core_clk), .i_nrst(nrst),
    .i_mgmt_clk(mgmt_clk), .i_mgmt_valid(valid), .i_mgmt_req(req), .o_mgmt_ready(ready),
    .o_mgmt_done(done), .o_mgmt_rdata(rdata), .i_events(ev), .o_irq(irq));
  mgmt_host_model mgmt_host_model_i (.i_mgmt_clk(mgmt_clk), .i_mgmt_ready(ready),
    .i_mgmt_done(done), .o_mgmt_valid(valid), .o_mgmt_req(req));

  // Core clock 4 ns; link clock 6 ns with an odd phase offset
  initial forever #2 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #3 mgmt_clk = ~mgmt_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Note the expected answer, then let the host perform the access
  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    exp_q.push_back(e);
    mgmt_host_model_i.access(wr, a, d);
  endtask

  // One-cycle event pulse, then time for status and interrupt to settle
  task automatic pulse(input logic [6:0] p);
    @(posedge core_clk);
    ev <= p;
    @(posedge core_clk);
    ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask

  // Every completion takes the oldest note; an unexpected one is a mismatch
  always @(posedge mgmt_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() > 0) check(rdata, exp_q.pop_front());
      else check(16'(exp_q.size()), 16'h0001);
    end
  end

  // Watchdog well beyond the expected run of a few microseconds
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h410E));
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    acc(1'b0, phy_event_pkg::EVENT_MASK_ADDR, 16'h0000, 16'h0000);
    acc(1'b0, phy_event_pkg::EVENT_STATUS_ADDR, 16'h0000, 16'h0000);
    acc(1'b0, 5'h05, 16'h0000, 16'h0000);
    acc(1'b1, phy_event_pkg::EVENT_STATUS_ADDR, 16'hFFFF, 16'h0000);
    acc(1'b1, 5'h05, 16'hFFFF, 16'h0000);
    acc(1'b0, phy_event_pkg::EVENT_MASK_ADDR, 16'h0000, 16'h0000);
    acc(1'b1, phy_event_pkg::EVENT_MASK_ADDR, 16'hFFFF, 16'h0000);
    acc(1'b0, phy_event_pkg::EVENT_MASK_ADDR, 16'h0000, 16'h5F80);
    // Each event alone unmasked, then random events under random masks
    for (int i = 0; i < 14; i++) begin
      v = (i < 7) ? (7'h01 << i) : 7'($urandom);
      m = (i < 7) ? 16'h0000 : (16'($urandom) & 16'h5F80);
      acc(1'b1, phy_event_pkg::EVENT_MASK_ADDR, m, 16'h0000);
      acc(1'b0, phy_event_pkg::EVENT_MASK_ADDR, 16'h0000, m);
      pulse(v);
      x = {1'b0, v[6], 1'b0, v[5:0], 7'h00};
      check({15'h0000, irq}, {15'h0000, |(x & ~m)});
      acc(1'b0, phy_event_pkg::EVENT_STATUS_ADDR, 16'h0000, x);
      acc(1'b0, phy_event_pkg::EVENT_STATUS_ADDR, 16'h0000, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
    end
    // A link-up held across reads survives each clear until it drops
    @(posedge core_clk);
    ev <= 7'h08;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 2; i++) acc(1'b0, phy_event_pkg::EVENT_STATUS_ADDR, 16'h0000, 16'h0400);
    @(posedge core_clk);
    ev <= '0;
    acc(1'b0, phy_event_pkg::EVENT_STATUS_ADDR, 16'h0000, 16'h0400);
    acc(1'b0, phy_event_pkg::EVENT_STATUS_ADDR, 16'h0000, 16'h0000);
    repeat (5) @(posedge mgmt_clk);
    check(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
